// ==== logic/ups_map.svh ====
`ifndef UPS_MAP_SVH
`define UPS_MAP_SVH

// Register byte offsets.
`define UPS_OFS_GO       12'h000
`define UPS_OFS_STATUS   12'h004
`define UPS_OFS_CONFIG   12'h008
`define UPS_OFS_WAKE     12'h00C
`define UPS_OFS_EVENT    12'h010
`define UPS_OFS_IRQ_EN   12'h014

// Go-request bit positions.
`define UPS_GO_SLEEP     0
`define UPS_GO_SNOOZE    1
`define UPS_GO_BASE      2
`define UPS_GO_DEV       3
`define UPS_GO_HOST      4
`define UPS_GO_DUAL_DEV  5
`define UPS_GO_DUAL_HOST 6
`define UPS_GO_W         7

// Config bit positions.
`define UPS_CFG_MAP_SEL  0
`define UPS_CFG_SINGLE   1

// State field codes.
`define UPS_ST_SLEEP     4'h0
`define UPS_ST_SNOOZE    4'h1
`define UPS_ST_BASE      4'h2
`define UPS_ST_DEV       4'h3
`define UPS_ST_HOST      4'h4
`define UPS_ST_DUAL      4'h5

// Reset values.
`define UPS_WAKE_RST     16'h0100

// PLL settling time and clock rate.
`define UPS_PLL_SETTLE_NS 250000
`define UPS_CLK_MHZ       200
`define UPS_PLL_SETTLE_CYC ((`UPS_PLL_SETTLE_NS * `UPS_CLK_MHZ) / 1000)

`endif

// ==== logic/ups_pkg.sv ====
package ups_pkg;

    typedef enum logic [2:0] {
        UPS_SLEEP,
        UPS_SNOOZE,
        UPS_BASE,
        UPS_DEV,
        UPS_HOST,
        UPS_DUAL
    } ups_pstate_t;

    typedef enum logic [2:0] {
        UPS_IDLE,
        UPS_STOP_CLK,
        UPS_STOP_HSPLL,
        UPS_STOP_BPLL,
        UPS_STOP_OSC,
        UPS_WAIT_OSC,
        UPS_WAIT_PLL
    } ups_step_t;

    typedef struct packed {
        logic osc_run;
        logic osc_clock_out;
        logic base_pll;
        logic device_hs_pll;
        logic host_hs_pll;
        logic hs_system_clock;
        logic device_clk_en;
        logic host_clk_en;
    } ups_clk_t;

    typedef struct packed {
        logic common_wr;
        logic device_wr;
        logic host_wr;
    } ups_access_t;

    typedef struct packed {
        logic active_function_flag;
        logic device_xfer_en;
        logic host_xfer_en;
        logic dev_nak_all;
        logic dev_setup_ack;
        logic host_transceiver_en;
    } ups_func_t;

endpackage

// ==== logic/ups_sequencer.sv ====
// Summary of operation
// - Host-active: osc, base, host PLL; device map read-only.
// - Entering host-active sets active-function flag.
// - Dual-active two-port: all clocks, all maps writable.
// - Dual via device request clears flag, device transfers.
// - Dual via host request sets flag, host transfers.
// - Dual-host substate: device NAKs every token.
// - Dual-host substate: still ACK endpoint-0 SETUP.
// - Single-port: map-select picks function and clock.
// - Single-port: no host or dual states.
// - Go bit starts transition; four-bit state readable.
// - Completion raises done event, gated interrupt output.
// - Distant targets pass through intermediate states.
// - Request for current state: no move, bit stays.
// - Sleep entry: HS PLL, base PLL, clock out, osc.
// - Sleep exit: gate oscillator until wake timer expires.
// - Wake timer register accessible in any state.
// - Snooze entry: clock out, HS PLL, base PLL.
// - Snooze exit: hold system clock 250 us.
// - Base-clock: osc and base PLL; common writable only.
// - Single-port device-active: map-select picks writable map.
//
// Added by the designer: the register addresses and register access over AHB-Lite.
`include "ups_map.svh"
`timescale 1ns/10ps
`default_nettype none

module ups_sequencer #(
    parameter int PLL_SETTLE_CYC = `UPS_PLL_SETTLE_CYC
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic [31:0]       hrdata,
    output logic              hreadyout,
    output logic              hresp,
    output ups_pkg::ups_clk_t    clk_ctrl,
    output ups_pkg::ups_access_t map_access,
    output ups_pkg::ups_func_t   func_ctrl,
    output logic [3:0]        power_state_field,
    output logic              irq_out_n
);

    logic                 wr_pend_r;
    logic [11:0]          wr_addr_r;
    logic [`UPS_GO_W-1:0] go_r;
    logic                 map_select_r;
    logic                 single_port_select_r;
    logic [15:0]          wake_timer_r;
    logic                 pm_done_event_r;
    logic                 pm_done_irq_enable_r;
    ups_pkg::ups_pstate_t state_r;
    ups_pkg::ups_pstate_t target_r;
    ups_pkg::ups_step_t   step_r;
    logic [31:0]          cnt_r;
    logic                 flag_r;
    logic                 busy_r;
    logic [`UPS_GO_W-1:0] go_act_r;
    logic                 done_pulse;
    ups_pkg::ups_pstate_t req_tgt;
    logic [`UPS_GO_W-1:0] req_bit;
    logic                 req_valid;
    ups_pkg::ups_pstate_t hop;
    logic                 hs_dual;

    function automatic logic [3:0] state_code(input ups_pkg::ups_pstate_t s);
        case (s)
            ups_pkg::UPS_SLEEP:  state_code = `UPS_ST_SLEEP;
            ups_pkg::UPS_SNOOZE: state_code = `UPS_ST_SNOOZE;
            ups_pkg::UPS_BASE:   state_code = `UPS_ST_BASE;
            ups_pkg::UPS_DEV:    state_code = `UPS_ST_DEV;
            ups_pkg::UPS_HOST:   state_code = `UPS_ST_HOST;
            ups_pkg::UPS_DUAL:   state_code = `UPS_ST_DUAL;
            default:             state_code = `UPS_ST_SLEEP;
        endcase
    endfunction

    function automatic logic is_active(input ups_pkg::ups_pstate_t s);
        is_active = (s == ups_pkg::UPS_DEV) || (s == ups_pkg::UPS_HOST) || (s == ups_pkg::UPS_DUAL);
    endfunction

    // The bus never stalls: writes land one cycle after their address phase.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
        end
        else if (hready)
        begin
            wr_pend_r <= hsel && htrans[1] && hwrite;
            wr_addr_r <= haddr[11:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (hready && hsel && htrans[1] && !hwrite)
        begin
            case (haddr[11:0])
                `UPS_OFS_GO:     hrdata <= {25'h0, go_r};
                `UPS_OFS_STATUS: hrdata <= {27'h0, flag_r, power_state_field};
                `UPS_OFS_CONFIG: hrdata <= {30'h0, single_port_select_r, map_select_r};
                `UPS_OFS_WAKE:   hrdata <= {16'h0, wake_timer_r};
                `UPS_OFS_EVENT:  hrdata <= {31'h0, pm_done_event_r};
                `UPS_OFS_IRQ_EN: hrdata <= {31'h0, pm_done_irq_enable_r};
                default:         hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Map-select is plain storage; correct timing is firmware's duty.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            map_select_r         <= 1'b0;
            single_port_select_r <= 1'b0;
            pm_done_irq_enable_r <= 1'b0;
        end
        else if (wr_pend_r && wr_addr_r == `UPS_OFS_CONFIG)
        begin
            map_select_r         <= hwdata[`UPS_CFG_MAP_SEL];
            single_port_select_r <= hwdata[`UPS_CFG_SINGLE];
        end
        else if (wr_pend_r && wr_addr_r == `UPS_OFS_IRQ_EN)
            pm_done_irq_enable_r <= hwdata[0];
    end

    // Wake timer is writable whatever the power state.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            wake_timer_r <= `UPS_WAKE_RST;
        else if (wr_pend_r && wr_addr_r == `UPS_OFS_WAKE)
            wake_timer_r <= hwdata[15:0];
    end

    // Done event is sticky; write one to clear, a new event wins.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pm_done_event_r <= 1'b0;
        else if (done_pulse)
            pm_done_event_r <= 1'b1;
        else if (wr_pend_r && wr_addr_r == `UPS_OFS_EVENT && hwdata[0])
            pm_done_event_r <= 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_out_n <= 1'b1;
        else
            irq_out_n <= !(pm_done_event_r && pm_done_irq_enable_r);
    end

    // Go bits: firmware sets, completion of the started request clears.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            go_r <= '0;
        else
        begin
            // Clear the started go bit on completion.
            if (done_pulse)
                go_r <= go_r & ~go_act_r;
            if (wr_pend_r && wr_addr_r == `UPS_OFS_GO)
                go_r <= (done_pulse ? (go_r & ~go_act_r) : go_r) | hwdata[`UPS_GO_W-1:0];
        end
    end

    // Pick the highest-priority pending go bit that names a new state.
    always_comb
    begin
        req_tgt   = ups_pkg::UPS_SLEEP;
        req_bit   = '0;
        req_valid = 1'b0;
        for (int i = `UPS_GO_W - 1; i >= 0; i--)
        begin
            if (go_r[i])
            begin
                case (i)
                    `UPS_GO_SLEEP:     req_tgt = ups_pkg::UPS_SLEEP;
                    `UPS_GO_SNOOZE:    req_tgt = ups_pkg::UPS_SNOOZE;
                    `UPS_GO_BASE:      req_tgt = ups_pkg::UPS_BASE;
                    `UPS_GO_DEV:       req_tgt = ups_pkg::UPS_DEV;
                    `UPS_GO_HOST:      req_tgt = ups_pkg::UPS_HOST;
                    default:           req_tgt = ups_pkg::UPS_DUAL;
                endcase
                req_bit = '0;
                req_bit[i] = 1'b1;
                req_valid = 1'b1;
                // Host and dual requests are dead in single-port mode.
                if (single_port_select_r && i >= `UPS_GO_HOST)
                    req_valid = 1'b0;
                // Same-state requests do nothing; dual substate swaps are allowed.
                if (req_tgt == state_r && req_tgt != ups_pkg::UPS_DUAL)
                    req_valid = 1'b0;
                if (req_tgt == ups_pkg::UPS_DUAL && state_r == ups_pkg::UPS_DUAL
                    && flag_r == (i == `UPS_GO_DUAL_HOST))
                    req_valid = 1'b0;
                if (req_valid)
                    break;
            end
        end
    end

    // Next hop toward the target passes through snooze and base.
    always_comb
    begin
        hop = target_r;
        case (state_r)
            ups_pkg::UPS_SLEEP:  hop = ups_pkg::UPS_SNOOZE;
            ups_pkg::UPS_SNOOZE: hop = (target_r == ups_pkg::UPS_SLEEP) ? ups_pkg::UPS_SLEEP : ups_pkg::UPS_BASE;
            ups_pkg::UPS_BASE:   hop = is_active(target_r) ? target_r : ups_pkg::UPS_SNOOZE;
            default:             hop = ups_pkg::UPS_BASE;
        endcase
        if (state_r == ups_pkg::UPS_DUAL && target_r == ups_pkg::UPS_DUAL)
            hop = ups_pkg::UPS_DUAL;
    end

    // One process sequences the power state and its clock steps.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_r    <= ups_pkg::UPS_SLEEP;
            target_r   <= ups_pkg::UPS_SLEEP;
            step_r     <= ups_pkg::UPS_IDLE;
            busy_r     <= 1'b0;
            go_act_r   <= '0;
            cnt_r      <= 32'h0000_0000;
            flag_r     <= 1'b0;
            done_pulse <= 1'b0;
        end
        else
        begin
            done_pulse <= 1'b0;
            case (step_r)
                ups_pkg::UPS_IDLE:
                begin
                    if (!busy_r && req_valid)
                    begin
                        busy_r   <= 1'b1;
                        target_r <= req_tgt;
                        go_act_r <= req_bit;
                    end
                    else if (busy_r && state_r == target_r
                             && !(state_r == ups_pkg::UPS_DUAL && go_act_r[`UPS_GO_DUAL_HOST] != flag_r))
                    begin
                        busy_r     <= 1'b0;
                        done_pulse <= 1'b1;
                    end
                    else if (busy_r && state_r == ups_pkg::UPS_DUAL && target_r == ups_pkg::UPS_DUAL)
                        flag_r <= go_act_r[`UPS_GO_DUAL_HOST];
                    else if (busy_r)
                    begin
                        if (hop == ups_pkg::UPS_SNOOZE && state_r != ups_pkg::UPS_SLEEP)
                            step_r <= ups_pkg::UPS_STOP_CLK;
                        else if (hop == ups_pkg::UPS_SLEEP)
                            step_r <= ups_pkg::UPS_STOP_HSPLL;
                        else if (state_r == ups_pkg::UPS_SLEEP)
                        begin
                            step_r <= ups_pkg::UPS_WAIT_OSC;
                            cnt_r  <= {16'h0, wake_timer_r};
                        end
                        else if (state_r == ups_pkg::UPS_SNOOZE)
                        begin
                            step_r <= ups_pkg::UPS_WAIT_PLL;
                            cnt_r  <= PLL_SETTLE_CYC;
                        end
                        else
                        begin
                            // Flag moves with the state, so it is right once the state shows.
                            if (hop == ups_pkg::UPS_DUAL)
                                flag_r <= go_act_r[`UPS_GO_DUAL_HOST];
                            else if (hop == ups_pkg::UPS_HOST || hop == ups_pkg::UPS_DEV)
                                flag_r <= (hop == ups_pkg::UPS_HOST);
                            state_r <= hop;
                        end
                    end
                end
                // Snooze entry stops clock output, then PLLs.
                ups_pkg::UPS_STOP_CLK:   step_r <= ups_pkg::UPS_STOP_HSPLL;
                // Sleep entry order: HS PLL, base PLL, clock out, osc.
                ups_pkg::UPS_STOP_HSPLL: step_r <= ups_pkg::UPS_STOP_BPLL;
                ups_pkg::UPS_STOP_BPLL:
                begin
                    if (hop == ups_pkg::UPS_SLEEP)
                        step_r <= ups_pkg::UPS_STOP_OSC;
                    else
                    begin
                        step_r  <= ups_pkg::UPS_IDLE;
                        state_r <= ups_pkg::UPS_SNOOZE;
                    end
                end
                ups_pkg::UPS_STOP_OSC:
                begin
                    step_r  <= ups_pkg::UPS_IDLE;
                    state_r <= ups_pkg::UPS_SLEEP;
                end
                // Clocks stay gated until the settle count ends.
                ups_pkg::UPS_WAIT_OSC, ups_pkg::UPS_WAIT_PLL:
                begin
                    if (cnt_r <= 32'h0000_0001)
                    begin
                        step_r  <= ups_pkg::UPS_IDLE;
                        state_r <= (step_r == ups_pkg::UPS_WAIT_OSC) ? ups_pkg::UPS_SNOOZE : ups_pkg::UPS_BASE;
                    end
                    else
                        cnt_r <= cnt_r - 32'h0000_0001;
                end
                default: step_r <= ups_pkg::UPS_IDLE;
            endcase
        end
    end

    assign power_state_field = state_code(state_r);
    assign hs_dual = (state_r == ups_pkg::UPS_DUAL);

    // Clock tree: osc, clock out and base PLL drop at the step that stops them; HS PLLs drop when the state leaves an active state.
    always_comb
    begin
        clk_ctrl = '0;
        case (state_r)
            ups_pkg::UPS_SLEEP:
                clk_ctrl.osc_run = (step_r == ups_pkg::UPS_WAIT_OSC);
            ups_pkg::UPS_SNOOZE:
            begin
                clk_ctrl.osc_run       = (step_r != ups_pkg::UPS_STOP_OSC);
                clk_ctrl.osc_clock_out = (step_r == ups_pkg::UPS_IDLE) || (step_r == ups_pkg::UPS_WAIT_PLL)
                                         || (step_r == ups_pkg::UPS_STOP_HSPLL);
                clk_ctrl.base_pll      = (step_r == ups_pkg::UPS_WAIT_PLL);
            end
            default:
            begin
                clk_ctrl.osc_run       = 1'b1;
                clk_ctrl.osc_clock_out = (step_r != ups_pkg::UPS_STOP_CLK) && (step_r != ups_pkg::UPS_STOP_HSPLL)
                                         && (step_r != ups_pkg::UPS_STOP_BPLL) || (step_r == ups_pkg::UPS_STOP_HSPLL
                                         && hop == ups_pkg::UPS_SLEEP) || (step_r == ups_pkg::UPS_STOP_BPLL
                                         && hop == ups_pkg::UPS_SLEEP);
                clk_ctrl.base_pll      = (step_r != ups_pkg::UPS_STOP_BPLL) && (step_r != ups_pkg::UPS_STOP_OSC);
                clk_ctrl.device_hs_pll = (step_r == ups_pkg::UPS_IDLE || step_r == ups_pkg::UPS_STOP_CLK)
                                         && (state_r == ups_pkg::UPS_DEV || hs_dual);
                clk_ctrl.host_hs_pll   = (step_r == ups_pkg::UPS_IDLE || step_r == ups_pkg::UPS_STOP_CLK)
                                         && (state_r == ups_pkg::UPS_HOST || hs_dual);
            end
        endcase
        clk_ctrl.hs_system_clock = clk_ctrl.device_hs_pll || clk_ctrl.host_hs_pll;
        // Single-port mode feeds only the selected function block.
        if (single_port_select_r)
        begin
            clk_ctrl.device_clk_en = clk_ctrl.hs_system_clock && !map_select_r;
            clk_ctrl.host_clk_en   = clk_ctrl.hs_system_clock && map_select_r;
        end
        else
        begin
            clk_ctrl.device_clk_en = clk_ctrl.device_hs_pll;
            clk_ctrl.host_clk_en   = clk_ctrl.host_hs_pll;
        end
    end

    // Register map write permissions per state.
    always_comb
    begin
        map_access = '0;
        map_access.common_wr = (state_r != ups_pkg::UPS_SLEEP) && (state_r != ups_pkg::UPS_SNOOZE);
        case (state_r)
            ups_pkg::UPS_DEV:
            begin
                map_access.device_wr = !single_port_select_r || !map_select_r;
                map_access.host_wr   = single_port_select_r && map_select_r;
            end
            ups_pkg::UPS_HOST:
                map_access.host_wr = 1'b1;
            ups_pkg::UPS_DUAL:
            begin
                map_access.device_wr = 1'b1;
                map_access.host_wr   = 1'b1;
            end
            default:
                map_access.device_wr = 1'b0;
        endcase
    end

    // Function transfer enables and dual-host device behaviour.
    always_comb
    begin
        func_ctrl = '0;
        func_ctrl.active_function_flag = flag_r;
        func_ctrl.host_transceiver_en  = !single_port_select_r && (state_r == ups_pkg::UPS_HOST || hs_dual);
        if (step_r == ups_pkg::UPS_IDLE && !busy_r)
        begin
            func_ctrl.device_xfer_en = (state_r == ups_pkg::UPS_DEV) || (hs_dual && !flag_r);
            func_ctrl.host_xfer_en   = (state_r == ups_pkg::UPS_HOST) || (hs_dual && flag_r);
        end
        // Device NAKs tokens but ACKs EP0 SETUP.
        func_ctrl.dev_nak_all   = hs_dual && flag_r;
        func_ctrl.dev_setup_ack = hs_dual && flag_r;
    end

endmodule

`default_nettype wire

// ==== verif/ups_sequencer_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ups_map.svh"
module ups_sequencer_bench;
    localparam int SETTLE = 20;
    logic                 hclk = 1'b0;
    logic                 hresetn = 1'b0;
    logic                 hsel = 1'b0;
    logic [31:0]          haddr = 32'h0;
    logic [1:0]           htrans = 2'h0;
    logic                 hwrite = 1'b0;
    logic [31:0]          hwdata = 32'h0;
    logic [31:0]          hrdata;
    logic                 hreadyout;
    logic                 hresp;
    ups_pkg::ups_clk_t    clk_ctrl;
    ups_pkg::ups_access_t map_access;
    ups_pkg::ups_func_t   func_ctrl;
    logic [3:0]           power_state_field;
    logic                 irq_out_n;
    logic [31:0]          rd;
    logic [7:0]           seen_st = 8'h00;
    int                   fails = 0;
    int                   n_checks = 0;
    int                   cyc = 0;
    int                   t0;
    ups_sequencer #(.PLL_SETTLE_CYC(SETTLE)) u_ups_sequencer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .clk_ctrl(clk_ctrl), .map_access(map_access),
        .func_ctrl(func_ctrl), .power_state_field(power_state_field), .irq_out_n(irq_out_n));
    initial
    begin
        forever #2.5 hclk = ~hclk;
    end
    always @(posedge hclk)
    begin
        seen_st[power_state_field[2:0]] <= 1'b1;
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fails++;
            tally_and_finish();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    // One single AHB transfer; entered just after a rising edge, read data lands in rd.
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic go(input int b, input logic [3:0] st);
        int n;
        bus(1'b1, `UPS_OFS_EVENT, 32'h1);
        seen_st = 8'h00;
        bus(1'b1, `UPS_OFS_GO, 32'h1 << b);
        n = 0;
        rd = 32'h0;
        while (rd[0] !== 1'b1 && n < 200)
        begin
            bus(1'b0, `UPS_OFS_EVENT, 32'h0);
            n++;
        end
        check("done event", rd, 32'h1);
        bus(1'b0, `UPS_OFS_STATUS, 32'h0);
        check("state field", rd[3:0], st);
        bus(1'b0, `UPS_OFS_GO, 32'h0);
        check("go bits", rd, 32'h0);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check("reset state", power_state_field, 4'h0);
        bus(1'b0, `UPS_OFS_WAKE, 32'h0);
        check("wake reset", rd, 32'h100);
        bus(1'b1, `UPS_OFS_WAKE, 32'h4);
        bus(1'b0, `UPS_OFS_WAKE, 32'h0);
        check("wake in sleep", rd, 32'h4);
        bus(1'b1, `UPS_OFS_IRQ_EN, 32'h1);
        t0 = cyc;
        go(`UPS_GO_BASE, 4'h2);
        check("wake gate time", {31'h0, cyc - t0 >= 4 + SETTLE}, 32'h1);
        check("via snooze", seen_st[1], 1'b1);
        check("irq low", irq_out_n, 1'b0);
        bus(1'b1, `UPS_OFS_IRQ_EN, 32'h0);
        go(`UPS_GO_HOST, 4'h4);
        check("irq masked", irq_out_n, 1'b1);
        check("host plls", {clk_ctrl.osc_run, clk_ctrl.base_pll, clk_ctrl.device_hs_pll, clk_ctrl.host_hs_pll}, 4'hD);
        check("host maps", map_access, 3'h5);
        bus(1'b0, `UPS_OFS_STATUS, 32'h0);
        check("host flag", rd[4], 1'b1);
        go(`UPS_GO_DUAL_DEV, 4'h5);
        check("dual plls", {clk_ctrl.device_hs_pll, clk_ctrl.host_hs_pll}, 2'h3);
        check("dual maps", map_access, 3'h7);
        check("dual dev func", func_ctrl[5:3], 3'h2);
        go(`UPS_GO_DUAL_HOST, 4'h5);
        check("dual host func", func_ctrl[5:3], 3'h5);
        check("nak and setup", {func_ctrl.dev_nak_all, func_ctrl.dev_setup_ack}, 2'h3);
        go(`UPS_GO_SLEEP, 4'h0);
        check("down path", seen_st[2:1], 2'h3);
        check("sleep clocks", clk_ctrl, 8'h00);
        // Map-select only moves while no function clock runs.
        bus(1'b1, `UPS_OFS_CONFIG, 32'h3);
        go(`UPS_GO_DEV, 4'h3);
        check("up path", seen_st[2:1], 2'h3);
        check("host fn clock", {clk_ctrl.device_clk_en, clk_ctrl.host_clk_en}, 2'h1);
        check("host fn map", {map_access.device_wr, map_access.host_wr}, 2'h1);
        check("port a xcvr", func_ctrl.host_transceiver_en, 1'b0);
        go(`UPS_GO_SNOOZE, 4'h1);
        bus(1'b1, `UPS_OFS_CONFIG, 32'h2);
        go(`UPS_GO_DEV, 4'h3);
        check("dev fn clock", {clk_ctrl.device_clk_en, clk_ctrl.host_clk_en}, 2'h2);
        check("dev fn map", {map_access.device_wr, map_access.host_wr, map_access.common_wr}, 3'h5);
        bus(1'b1, `UPS_OFS_EVENT, 32'h1);
        bus(1'b1, `UPS_OFS_GO, 32'h1 << `UPS_GO_DEV);
        repeat (40) @(posedge hclk);
        bus(1'b0, `UPS_OFS_EVENT, 32'h0);
        check("same state event", rd, 32'h0);
        bus(1'b1, `UPS_OFS_GO, 32'h1 << `UPS_GO_HOST);
        repeat (40) @(posedge hclk);
        bus(1'b0, `UPS_OFS_GO, 32'h0);
        check("pending go bits", rd, 32'h18);
        bus(1'b0, `UPS_OFS_STATUS, 32'h0);
        check("single stays", rd[3:0], 4'h3);
        tally_and_finish();
    end
endmodule
bind ups_sequencer ups_sequencer_chk #(.PLL_SETTLE_CYC(PLL_SETTLE_CYC)) u_ups_sequencer_chk (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .clk_ctrl(clk_ctrl), .map_access(map_access), .func_ctrl(func_ctrl),
    .power_state_field(power_state_field), .irq_out_n(irq_out_n));
`default_nettype wire

// ==== verif/ups_sequencer_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module ups_sequencer_chk #(
    parameter int PLL_SETTLE_CYC = 20
) (
    input wire logic                 hclk,
    input wire logic                 hresetn,
    input wire logic                 hsel,
    input wire logic [31:0]          haddr,
    input wire logic [1:0]           htrans,
    input wire logic                 hwrite,
    input wire logic [2:0]           hsize,
    input wire logic [31:0]          hwdata,
    input wire logic                 hready,
    input wire logic [31:0]          hrdata,
    input wire logic                 hreadyout,
    input wire logic                 hresp,
    input wire ups_pkg::ups_clk_t    clk_ctrl,
    input wire ups_pkg::ups_access_t map_access,
    input wire ups_pkg::ups_func_t   func_ctrl,
    input wire logic [3:0]           power_state_field,
    input wire logic                 irq_out_n
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [31:0] snz_cnt_r;
    // Counts how long the state field has shown snooze, to bound the PLL settling gate.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            snz_cnt_r <= 32'h0;
        else if (power_state_field == 4'h1)
            snz_cnt_r <= snz_cnt_r + 32'h1;
        else
            snz_cnt_r <= 32'h0;
    end
    chk_host_clocks: assert property ($rose(power_state_field == 4'h4) |-> clk_ctrl.osc_run && clk_ctrl.base_pll
        && clk_ctrl.host_hs_pll && map_access.common_wr && map_access.host_wr && !map_access.device_wr) else $error("host state setup wrong");
    chk_host_flag: assert property ($rose(power_state_field == 4'h4) |-> func_ctrl.active_function_flag)
        else $error("host entry flag low");
    chk_dual_all: assert property ($rose(power_state_field == 4'h5) |-> clk_ctrl.device_hs_pll && clk_ctrl.host_hs_pll
        && map_access.device_wr && map_access.host_wr && map_access.common_wr) else $error("dual state setup wrong");
    chk_dual_xfer: assert property ($rose(power_state_field == 4'h5) |=> (func_ctrl.device_xfer_en
        == !func_ctrl.active_function_flag) && (func_ctrl.host_xfer_en == func_ctrl.active_function_flag)) else $error("dual xfer wrong");
    chk_nak_setup: assert property ($rose(func_ctrl.active_function_flag) && power_state_field == 4'h5
        |-> func_ctrl.dev_nak_all && func_ctrl.dev_setup_ack) else $error("dual host substate device answer wrong");
    chk_base_only: assert property ($rose(power_state_field == 4'h2) |-> clk_ctrl.osc_run && clk_ctrl.base_pll
        && !clk_ctrl.device_hs_pll && !clk_ctrl.host_hs_pll && !map_access.device_wr && !map_access.host_wr) else $error("base state wrong");
    chk_pll_order: assert property ($fell(clk_ctrl.base_pll) |-> !clk_ctrl.device_hs_pll && !clk_ctrl.host_hs_pll
        && !clk_ctrl.hs_system_clock) else $error("base pll stopped too early");
    chk_osc_last: assert property ($fell(clk_ctrl.osc_run) |-> !clk_ctrl.base_pll && !$past(clk_ctrl.osc_clock_out))
        else $error("oscillator halted too early");
    chk_pll_settle: assert property ($changed(power_state_field) && $past(power_state_field) == 4'h1
        && power_state_field != 4'h0 |-> snz_cnt_r >= PLL_SETTLE_CYC - 2) else $error("snooze exit too fast");
    chk_single_clk: assert property (power_state_field == 4'h3 |-> clk_ctrl.device_clk_en != clk_ctrl.host_clk_en)
        else $error("function clocks both fed");
endmodule
`default_nettype wire
